// file: bench/rtcssa_core_tb.sv
// Purpose: self-checking bench for the sub-second alarm and control word
// Assumes: DIV_32K of 2, so a sub-second step every 16 clocks
// Notes:   random data from a fixed-seed lfsr; expectations from bench functions
`timescale 1ns/100ps
`default_nettype none
`include "rtcssa_consts.svh"
module rtcssa_core_tb
   import rtcssa_pkg::*;
;
   localparam logic [15:0] DIV = 16'h0002;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        sys_rst  = 1'b0;
   logic        blk_rst  = 1'b0;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [3:0]  sel      = 4'h0;
   logic [31:0] wdat     = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        wake;
   logic        sqw;
   logic [31:0] seed     = 32'h83FE;
   int          n_errors = 0;
   int          total_checks = 0;

   rtcssa_core #(.DIV_32K(DIV)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .system_reset_i(sys_rst),
      .block_peripheral_reset_i(blk_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wake_o(wake), .sqw_o(sqw));

   // ----------------------------------------------------------------
   // clock, helpers and checks
   // ----------------------------------------------------------------
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   // galois lfsr, taps for a maximal 32-bit sequence
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         if (s[i]) o[8*i +: 8] = d[8*i +: 8];
      return o;
   endfunction

   // square wave edges expected in n clocks for a frequency select
   function automatic int exp_edges(input logic [1:0] f, input int n);
      return n / (int'(DIV) * (f[1] ? 4 : (f[0] ? 32 : 16384)));
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, lo, hi, input string msg);
      total_checks++;
      if (got < lo || got > hi)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %0d", $time, msg, got);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) chk(32'h0, 32'h1, "no ack");
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, 4'hF, q);
   endtask

   task automatic count_edges(input int n, output int e);
      logic last;
      e = 0;
      @(posedge clk_i);
      last = sqw;
      repeat (n)
      begin
         @(posedge clk_i);
         if (sqw !== last) e++;
         last = sqw;
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      #(40 * 40000);
      n_errors++;
      conclude();
   end

   initial
   begin
      logic [31:0] q;
      logic [31:0] ref_w;
      logic [3:0]  s;
      int          e;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, ready bit excluded as it pulses on its own
      rd(`RTCSSA_OFF_RELOAD, q);
      chk(q, `RTCSSA_RST_RELOAD, "reload reset");
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & ~32'h10, 32'h0, "ctrl reset");
      chk({29'h0, irq, wake, sqw}, 32'h0, "outputs reset");
      // random byte-lane writes of the reload word
      ref_w = 32'h0;
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         s = (i == 0) ? 4'hF : seed[3:0];
         wb(1'b1, `RTCSSA_OFF_RELOAD, seed, s, q);
         ref_w = merge(ref_w, seed, s);
         rd(`RTCSSA_OFF_RELOAD, q);
         chk(q, ref_w, "reload rw");
      end
      // unmapped offset reads zero and ignores writes
      wr(8'h14, seed);
      rd(8'h14, q);
      chk(q, 32'h0, "unmapped");
      // clock enable guarded by the write-protect-release bit
      wr(`RTCSSA_OFF_CTRL, 32'h0000_0001);
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h8001, 32'h0, "enable while protected");
      wr(`RTCSSA_OFF_CTRL, 32'h0000_8000);
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h8008, 32'h8000, "released, not busy");
      wr(`RTCSSA_OFF_CTRL, 32'h0000_8001);
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h8001, 32'h8001, "enable released");
      // each warm reset clears only the release bit
      for (int k = 0; k < 2; k++)
      begin
         wr(`RTCSSA_OFF_CTRL, 32'h0000_8001);
         @(posedge clk_i);
         if (k == 0) sys_rst <= 1'b1; else blk_rst <= 1'b1;
         @(posedge clk_i);
         sys_rst <= 1'b0;
         blk_rst <= 1'b0;
         rd(`RTCSSA_OFF_CTRL, q);
         chk(q & 32'h8001, 32'h0001, "warm reset");
      end
      // alarm three steps from wrap; the enable write also tries to drop bit 0
      wr(`RTCSSA_OFF_IMASK, 32'h1);
      wr(`RTCSSA_OFF_RELOAD, 32'hFFFF_FFFD);
      wr(`RTCSSA_OFF_CTRL, 32'h0000_0004);
      repeat (16) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0, "early alarm");
      e = 0;
      while (wake !== 1'b1 && e < 120)
      begin
         @(posedge clk_i);
         e++;
      end
      chk({31'h0, wake}, 32'h1, "alarm wake");
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1, "alarm irq");
      // writing one to the flag has no effect; it stays until cleared
      wr(`RTCSSA_OFF_CTRL, 32'h0000_0080);
      repeat (40) @(posedge clk_i);
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h0085, 32'h0081, "pending held");
      wr(`RTCSSA_OFF_CTRL, 32'h0000_0000);
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h0081, 32'h0001, "pending cleared");
      repeat (2) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0, "wake drop");
      // sticky status, mask and write-one-to-clear
      rd(`RTCSSA_OFF_ISTAT, q);
      chk(q & 32'h1, 32'h1, "status sticky");
      wr(`RTCSSA_OFF_IMASK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(`RTCSSA_OFF_IMASK, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      wr(`RTCSSA_OFF_ISTAT, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0, "status cleared");
      // synchronized read: seconds stay zero, far from the first roll-over
      rd(`RTCSSA_OFF_CTRL, q);
      chk(q & 32'h10, 32'h10, "ready window");
      rd(`RTCSSA_OFF_SEC, q);
      chk(q, 32'h0, "synced seconds");
      // square wave for every select, with async read set alongside
      for (int f = 0; f < 4; f++)
      begin
         wr(`RTCSSA_OFF_CTRL, 32'h4100 | (32'(f) << 9));
         rd(`RTCSSA_OFF_CTRL, q);
         chk(q & 32'h4700, 32'h4100 | (32'(f) << 9), "ctrl fields");
         rd(`RTCSSA_OFF_SEC, q);
         chk(q, 32'h0, "live seconds");
         count_edges(256, e);
         chk_rng(e, exp_edges(f[1:0], 256) - 1, exp_edges(f[1:0], 256) + 1,
                 "wave edges");
      end
      wr(`RTCSSA_OFF_CTRL, 32'h0000_0400);
      count_edges(256, e);
      chk_rng(e + int'(sqw), 0, 0, "wave off");
      conclude();
   end
endmodule
`default_nettype wire

// file: hdl/rtcssa_consts.svh
// Purpose: constants of the sub-second alarm and control block
// Assumes: 25 MHz clk_i, byte addresses on classic Wishbone
// Notes:   definitions only
//
// What this block does
// RL1: alarm counter loads the reload value at start and expiry, counts up, fires on wrap
// RL2: clock-enable field writable only while write-protect-release bit 15 is one
// RL3: write-protect-release bit clears on system, soft and block peripheral reset; the core has no soft reset input, only system and block peripheral
// RL4: async-read bit 14 returns live seconds and sub-seconds; software repeats reads
// RL5: with async-read off, software reads counters only while ready is one
// RL6: frequency select 10:9: 00 gives 1Hz, 01 gives 512Hz, 1x gives 4kHz
// RL7: square wave reaches the pin only while enable bit 8 is one
// RL8: sub-second alarm pending flag bit 7 sets when the alarm occurs
// RL9: pending flag acts as a wake-up request to the processor
// RL10: reload, async-read, frequency select, wave enable and pending flag reset to zero
// RL11: ready pulses high for 120us after the counter views update
// RL12: sub-second alarm becomes an interrupt only while enable bit 2 is one
// RL13: software sets write-protect-release and checks busy before writing clock enable
// RL14: pending flag holds until software writes zero to it
`ifndef RTCSSA_CONSTS_SVH
`define RTCSSA_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTCSSA_OFF_SEC    8'h00
`define RTCSSA_OFF_SSEC   8'h04
`define RTCSSA_OFF_RELOAD 8'h0C
`define RTCSSA_OFF_CTRL   8'h10
`define RTCSSA_OFF_ISTAT  8'h1C
`define RTCSSA_OFF_IMASK  8'h20

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define RTCSSA_B_WP      15
`define RTCSSA_B_ACRE    14
`define RTCSSA_B_FSEL_HI 10
`define RTCSSA_B_FSEL_LO 9
`define RTCSSA_B_SQW_EN  8
`define RTCSSA_B_PEND    7
`define RTCSSA_B_READY   4
`define RTCSSA_B_BUSY    3
`define RTCSSA_B_ALM_EN  2
`define RTCSSA_B_CLK_EN  0
`define RTCSSA_I_ALARM   0
`define RTCSSA_I_READY   1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RTCSSA_RST_RELOAD 32'h0000_0000
`define RTCSSA_ALL_ONES   32'hFFFF_FFFF
`define RTCSSA_CLK_NS     120'd40
`define RTCSSA_READY_NS   120'd120000
`define RTCSSA_READY_CYC  12'((`RTCSSA_READY_NS + `RTCSSA_CLK_NS - 1) / `RTCSSA_CLK_NS)
`define RTCSSA_DIV_32K    16'h02FB

`endif

// file: hdl/rtcssa_core.sv
// Purpose: sub-second alarm, control word, counters and square wave
// Assumes: one 25 MHz clock; rst_i is the power-on reset
// Notes:   warm resets arrive from logic on the same clock
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rtcssa_consts.svh"
module rtcssa_core
   import rtcssa_pkg::*;
#(
   parameter logic [15:0] DIV_32K = `RTCSSA_DIV_32K
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        system_reset_i,
   input  wire logic        block_peripheral_reset_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   output logic             wake_o,
   output logic             sqw_o
);
   // ----------------------------------------------------------------
   // bus front end and time base
   // ----------------------------------------------------------------
   rtcssa_core_t   st_ff;
   rtcssa_core_t   nxt_st;
   rtcssa_wb_req_t req;
   logic           wr;
   logic           rd;
   logic [31:0]    bmask;
   logic           tick32;
   logic           tick4k;
   logic           expire;
   logic [31:0]    ctrl_rd;
   logic [31:0]    wdat;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                  sel: wb_sel_i, dat: wb_dat_i};

   rtcssa_wb_slave u_wb (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .req_i   (req),
      .ack_o   (wb_ack_o),
      .wr_o    (wr),
      .rd_o    (rd),
      .bmask_o (bmask)
   );

   rtcssa_tick_div #(.DIV(DIV_32K)) u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (tick32)
   );

   // sub-second step is every eighth oscillator edge
   assign tick4k = tick32 && (st_ff.pre[2:0] == 3'h7);
   assign expire = st_ff.alm_en && tick4k && (st_ff.alarm_cnt == `RTCSSA_ALL_ONES); // RL1

   // control word as software sees it; busy never rises here
   always_comb
   begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[`RTCSSA_B_WP] = st_ff.wp;
      ctrl_rd[`RTCSSA_B_ACRE] = st_ff.acre;
      ctrl_rd[`RTCSSA_B_FSEL_HI:`RTCSSA_B_FSEL_LO] = st_ff.fsel;
      ctrl_rd[`RTCSSA_B_SQW_EN] = st_ff.sqw_en;
      ctrl_rd[`RTCSSA_B_PEND] = st_ff.pend;
      ctrl_rd[`RTCSSA_B_READY] = (st_ff.rdy_cnt != 12'h000);
      ctrl_rd[`RTCSSA_B_ALM_EN] = st_ff.alm_en;
      ctrl_rd[`RTCSSA_B_CLK_EN] = st_ff.clk_en;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // order matters: software writes first, hardware events last so a
   // hardware set in the same cycle as a software clear is never lost
   always_comb
   begin
      nxt_st = st_ff;
      wdat = 32'h0000_0000;
      if (wr)
      begin
         case (wb_adr_i)
            `RTCSSA_OFF_RELOAD:
            begin
               nxt_st.reload = (st_ff.reload & ~bmask) | (wb_dat_i & bmask);
               nxt_st.alarm_cnt = nxt_st.reload; // RL1
            end
            `RTCSSA_OFF_CTRL:
            begin
               wdat = (ctrl_rd & ~bmask) | (wb_dat_i & bmask);
               nxt_st.wp = wdat[`RTCSSA_B_WP];
               if (st_ff.wp)
                  nxt_st.clk_en = wdat[`RTCSSA_B_CLK_EN]; // RL2
               nxt_st.acre = wdat[`RTCSSA_B_ACRE];
               nxt_st.fsel = wdat[`RTCSSA_B_FSEL_HI:`RTCSSA_B_FSEL_LO];
               nxt_st.sqw_en = wdat[`RTCSSA_B_SQW_EN];
               if (!wdat[`RTCSSA_B_PEND])
                  nxt_st.pend = 1'b0; // RL14
               nxt_st.alm_en = wdat[`RTCSSA_B_ALM_EN];
               if (wdat[`RTCSSA_B_ALM_EN] && !st_ff.alm_en)
                  nxt_st.alarm_cnt = st_ff.reload; // RL1
            end
            `RTCSSA_OFF_ISTAT:
               nxt_st.ist = st_ff.ist & ~(wb_dat_i[1:0] & bmask[1:0]);
            `RTCSSA_OFF_IMASK:
               nxt_st.imask = (st_ff.imask & ~bmask[1:0]) | (wb_dat_i[1:0] & bmask[1:0]);
            default:
               nxt_st.rdat = st_ff.rdat;
         endcase
      end

      // warm resets touch the write protect only
      if (system_reset_i || block_peripheral_reset_i)
         nxt_st.wp = 1'b0; // RL3

      // read data registered with the ack; unmapped reads give zero
      if (rd)
      begin
         case (wb_adr_i)
            `RTCSSA_OFF_SEC:
               nxt_st.rdat = st_ff.acre ? st_ff.sec : st_ff.sec_view; // RL4
            `RTCSSA_OFF_SSEC:
               nxt_st.rdat = {24'h000000, st_ff.acre ? st_ff.ssec[7:0] : st_ff.ssec_view[7:0]};
            `RTCSSA_OFF_RELOAD:
               nxt_st.rdat = st_ff.reload;
            `RTCSSA_OFF_CTRL:
               nxt_st.rdat = ctrl_rd;
            `RTCSSA_OFF_ISTAT:
               nxt_st.rdat = {30'h00000000, st_ff.ist};
            `RTCSSA_OFF_IMASK:
               nxt_st.rdat = {30'h00000000, st_ff.imask};
            default:
               nxt_st.rdat = 32'h0000_0000;
         endcase
      end

      // oscillator prescaler runs free; it also feeds the square wave
      if (tick32)
         nxt_st.pre = st_ff.pre + 15'h0001;

      // time keeping and synchronized views
      if (st_ff.rdy_cnt != 12'h000)
         nxt_st.rdy_cnt = st_ff.rdy_cnt - 12'h001;
      if (tick4k && st_ff.clk_en)
      begin
         nxt_st.ssec = st_ff.ssec + 12'h001;
         if (st_ff.ssec == 12'hFFF)
            nxt_st.sec = st_ff.sec + 32'h0000_0001;
         nxt_st.ssec_view = nxt_st.ssec;
         nxt_st.sec_view = nxt_st.sec;
         nxt_st.rdy_cnt = `RTCSSA_READY_CYC; // RL11
         if (st_ff.rdy_cnt == 12'h000)
            nxt_st.ist[`RTCSSA_I_READY] = 1'b1;
      end

      // alarm counter steps up; on wrap reload and raise the flag
      if (st_ff.alm_en && tick4k)
         nxt_st.alarm_cnt = expire ? st_ff.reload : st_ff.alarm_cnt + 32'h0000_0001; // RL1
      if (expire)
      begin
         nxt_st.pend = 1'b1; // RL8
         nxt_st.ist[`RTCSSA_I_ALARM] = 1'b1; // RL12
      end

      // square wave: bit 2 is 4kHz, bit 5 is 512Hz, bit 14 is 1Hz
      case (st_ff.fsel)
         2'b00:   nxt_st.sqw = st_ff.sqw_en && st_ff.pre[14]; // RL6 RL7
         2'b01:   nxt_st.sqw = st_ff.sqw_en && st_ff.pre[5];  // RL6 RL7
         default: nxt_st.sqw = st_ff.sqw_en && st_ff.pre[2];  // RL6 RL7
      endcase

      nxt_st.wake = st_ff.pend; // RL9
      nxt_st.irq = |(nxt_st.ist & nxt_st.imask);
   end

   // power-on reset clears everything to zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '0; // RL10
      else
         st_ff <= nxt_st;
   end

   assign wb_dat_o = st_ff.rdat;
   assign irq_o = st_ff.irq;
   assign wake_o = st_ff.wake;
   assign sqw_o = st_ff.sqw;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_RELOAD: assert property (expire && !wr |=> st_ff.alarm_cnt == $past(st_ff.reload)) // RL1
      else $error("alarm counter not reloaded on wrap");
   AST_WP: assert property (wr && wb_adr_i == `RTCSSA_OFF_CTRL && !st_ff.wp
                            |=> st_ff.clk_en == $past(st_ff.clk_en)) // RL2
      else $error("clock enable changed while protected");
   AST_WARM: assert property ((system_reset_i || block_peripheral_reset_i) |=> !st_ff.wp) // RL3
      else $error("write protect survived warm reset");
   AST_ACRE: assert property (rd && wb_adr_i == `RTCSSA_OFF_SEC && st_ff.acre
                              |=> wb_ack_o && wb_dat_o == $past(st_ff.sec)) // RL4
      else $error("async read did not return live seconds");
   AST_FSEL: assert property (st_ff.sqw_en && st_ff.fsel == 2'b00 |=> sqw_o == $past(st_ff.pre[14])) // RL6
      else $error("1Hz select drives wrong wave");
   AST_SQW_OFF: assert property (!st_ff.sqw_en[*2] |-> !sqw_o) // RL7
      else $error("square wave active while disabled");
   AST_PEND: assert property (expire |=> st_ff.pend ##1 wake_o) // RL8 RL9
      else $error("alarm did not set pending and wake");
   AST_POR: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> st_ff.reload == `RTCSSA_RST_RELOAD
                             && !st_ff.acre && st_ff.fsel == 2'b00 && !st_ff.sqw_en && !st_ff.pend) // RL10
      else $error("power-on reset values wrong");
   AST_READY: assert property (tick4k && st_ff.clk_en |=> st_ff.rdy_cnt == `RTCSSA_READY_CYC) // RL11
      else $error("ready window not started");
   AST_IRQ_EN: assert property ($rose(st_ff.ist[`RTCSSA_I_ALARM]) |-> $past(st_ff.alm_en)) // RL12
      else $error("alarm interrupt while disabled");
   AST_CLR: assert property (wr && wb_adr_i == `RTCSSA_OFF_CTRL && bmask[`RTCSSA_B_PEND]
                             && !wb_dat_i[`RTCSSA_B_PEND] && !expire |=> !st_ff.pend) // RL14
      else $error("pending flag not cleared by zero write");

   // ----------------------------------------------------------------
   // bus handshake and read paths
   // ----------------------------------------------------------------
   // a held request must be answered in the very next cycle
   AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // RL2
      else $error("request not acknowledged in one cycle");
   // ack is a single pulse, so a held request is never taken twice
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) // RL2
      else $error("ack stood for more than one cycle");
   AST_UNMAPPED: assert property (rd && wb_adr_i == 8'h14 |=> wb_dat_o == 32'h0000_0000) // RL10
      else $error("unmapped offset returned data");
   AST_SYNC_RD: assert property (rd && wb_adr_i == `RTCSSA_OFF_SEC && !st_ff.acre
                                 |=> wb_dat_o == $past(st_ff.sec_view)) // RL4
      else $error("synchronized read did not return the view");

   // ----------------------------------------------------------------
   // control word, alarm and outputs
   // ----------------------------------------------------------------
   // once released, the enable bit follows the written data
   AST_CLK_EN_SET: assert property (wr && wb_adr_i == `RTCSSA_OFF_CTRL && st_ff.wp && wb_sel_i[0]
                                    |=> st_ff.clk_en == $past(wb_dat_i[0])) // RL2
      else $error("clock enable write lost while released");
   AST_RELOAD_WR: assert property (wr && wb_adr_i == `RTCSSA_OFF_RELOAD
                                   && !(st_ff.alm_en && tick4k)
                                   |=> st_ff.alarm_cnt == st_ff.reload) // RL1
      else $error("alarm counter not loaded on reload write");
   AST_ISTAT: assert property (expire |=> st_ff.ist[`RTCSSA_I_ALARM]) // RL8
      else $error("alarm status bit not set on expiry");
   AST_IRQ_OUT: assert property (expire && st_ff.imask[`RTCSSA_I_ALARM] |=> irq_o) // RL12
      else $error("unmasked alarm did not raise irq");
   // the flag only falls through a software write to the control word
   AST_PEND_HOLD: assert property (st_ff.pend && !(wr && wb_adr_i == `RTCSSA_OFF_CTRL)
                                   |=> st_ff.pend) // RL14
      else $error("pending flag dropped without a clear");
   AST_WAKE: assert property (wake_o == $past(st_ff.pend)) // RL9
      else $error("wake does not follow pending flag");
   AST_SQW_4K: assert property (st_ff.sqw_en && st_ff.fsel[1]
                                |=> sqw_o == $past(st_ff.pre[2])) // RL6
      else $error("4kHz select drives wrong wave");
   AST_SQW_512: assert property (st_ff.sqw_en && st_ff.fsel == 2'b01
                                 |=> sqw_o == $past(st_ff.pre[5])) // RL6
      else $error("512Hz select drives wrong wave");
   // the ready window never restarts without a sub-second step
   AST_RDY_IDLE: assert property (st_ff.rdy_cnt == 12'h000 && !(tick4k && st_ff.clk_en)
                                  |=> st_ff.rdy_cnt == 12'h000) // RL11
      else $error("ready window started without a step");

   COV_WARM: cover property (st_ff.wp && system_reset_i ##1 !st_ff.wp);
   COV_ACRE: cover property (rd && wb_adr_i == `RTCSSA_OFF_SEC && st_ff.acre);
   COV_EXPIRE: cover property (expire ##1 irq_o);
   COV_READY: cover property (tick4k && st_ff.clk_en ##1 st_ff.rdy_cnt != 12'h000);
   COV_CLK_EN: cover property (st_ff.wp && wr && wb_adr_i == `RTCSSA_OFF_CTRL ##1 st_ff.clk_en);
endmodule
`default_nettype wire

// file: hdl/rtcssa_pkg.sv
// Purpose: types shared by the sub-second alarm block
// Assumes: constants come from rtcssa_consts.svh
// Notes:   every module keeps its state in one of these structs
package rtcssa_pkg;

   // bundled wishbone request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rtcssa_wb_req_t;

   typedef struct packed {
      logic ack;
   } rtcssa_wb_st_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } rtcssa_div_st_t;

   typedef struct packed {
      logic [31:0] reload;
      logic [31:0] alarm_cnt;
      logic [31:0] sec;
      logic [11:0] ssec;
      logic [31:0] sec_view;
      logic [11:0] ssec_view;
      logic [11:0] rdy_cnt;
      logic [14:0] pre;
      logic        wp;
      logic        acre;
      logic [1:0]  fsel;
      logic        sqw_en;
      logic        pend;
      logic        alm_en;
      logic        clk_en;
      logic [1:0]  ist;
      logic [1:0]  imask;
      logic        irq;
      logic        sqw;
      logic        wake;
      logic [31:0] rdat;
   } rtcssa_core_t;

endpackage

// file: hdl/rtcssa_tick_div.sv
// Purpose: one-cycle enable pulse every DIV clocks
// Assumes: DIV of at least 2
// Notes:   stands in for the 32kHz oscillator edge
`timescale 1ns/100ps
`default_nettype none
module rtcssa_tick_div
   import rtcssa_pkg::*;
#(
   parameter logic [15:0] DIV = 16'h02FB
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   rtcssa_div_st_t st_ff;
   rtcssa_div_st_t nxt_st;

   // free running count, pulse on the last step
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.tick = (st_ff.cnt == DIV - 16'h0001);
      nxt_st.cnt = nxt_st.tick ? 16'h0000 : st_ff.cnt + 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign tick_o = st_ff.tick;
endmodule
`default_nettype wire

// file: hdl/rtcssa_wb_slave.sv
// Purpose: classic wishbone handshake and byte-lane mask
// Assumes: master holds the request until it sees ack
// Notes:   ack one cycle after the request, dropped the cycle after
`timescale 1ns/100ps
`default_nettype none
module rtcssa_wb_slave
   import rtcssa_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire rtcssa_wb_req_t req_i,
   output logic                ack_o,
   output logic                wr_o,
   output logic                rd_o,
   output logic [31:0]         bmask_o
);
   rtcssa_wb_st_t st_ff;
   rtcssa_wb_st_t nxt_st;
   logic          take;

   // a request is taken once; the ack cycle itself starts nothing
   assign take = req_i.cyc && req_i.stb && !st_ff.ack;
   assign wr_o = take && req_i.we;
   assign rd_o = take && !req_i.we;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ack = take;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // expand sel into a bit mask
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign bmask_o[g*8 +: 8] = {8{req_i.sel[g]}};
      end
   endgenerate

   assign ack_o = st_ff.ack;
endmodule
`default_nettype wire
